// file: hdl/adc_ctrl.sv
// converter control and configuration registers with ahb-lite slave
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
// Behaviour
// RULE_01: bits 5:3 of control pick input channel 0..7 by binary code.
// RULE_02: small package variant: channel codes 5, 6, 7 select no input.
// RULE_03: control bit 0 powers the converter; cleared means fully off.
// RULE_04: justify bit 7 set: right justified, upper six bits of high read zero.
// RULE_05: justify bit clear: left justified, lower six bits of low read zero.
// RULE_06: clock select 00 /2, 01 /8, 10 /32, 11 internal rc oscillator. The code gives a bit time of 1, 4, 16 or 80 clock cycles.
// RULE_07: software sets go bit only while powered and after acquisition time.
// RULE_08: on completion load result, clear go bit, set done flag.
// RULE_09: software waits two bit times after a conversion before next acquisition.
module adc_ctrl (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        small_pkg_i,
   input  wire logic [9:0]  conv_data_i,
   output logic             conv_power_o,
   output logic [7:0]       chan_enable_o,
   output logic             conv_sample_o,
   output logic             conv_tick_o,
   output logic [3:0]       pin_analog_config_o,
   output logic             irq_o
);
   logic [7:0]              control_r;
   logic [7:0]              config_r;
   logic                    done_flag_r;
   logic                    done_mask_r;
   logic                    small_r;
   logic                    wr_pend_r;
   logic                    rd_pend_r;
   logic [7:0]              addr_r;
   logic [3:0]              bit_cnt_r;
   adc_ctrl_pkg::conv_state_t state_r;
   adc_ctrl_pkg::conv_state_t state_nxt;
   logic                    tick;
   logic                    done_evt;
   logic                    go_set;
   logic                    flag_clr;
   logic [7:0]              res_high;
   logic [7:0]              res_low;
   logic                    addr_ok;
   logic                    take;
   logic [7:0]              rd_val;
   logic [7:0]              control_nxt;
   logic [2:0]              strap_sync_r;
   logic                    wr_control;
   logic                    wr_config;
   logic                    wr_mask;

   // address phase taken when selected, nonsequential or sequential, and bus ready
   assign take    = hsel_i && htrans_i[1] && hready_i;
   assign addr_ok = (haddr_i[1:0] == 2'h0) && (haddr_i[31:10] == 22'h000000);

   // capture address phase; the index is held through a read's wait state
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end else begin
         wr_pend_r <= take && hwrite_i && addr_ok;
         rd_pend_r <= take && !hwrite_i;
         if (take) begin
            addr_r <= addr_ok ? haddr_i[9:2] : 8'hFF;
         end
      end
   end

   // a read costs one wait state so its data leave a flop and already see
   // a write that ended at the address edge; writes never wait
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= !(take && !hwrite_i);
         hresp_o     <= 1'b0;
      end
   end

   // read data captured in the wait state; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hrdata_o <= 32'h00000000;
      end else if (rd_pend_r) begin
         hrdata_o <= {24'h000000, rd_val};
      end
   end

   // strap pin through three flops; a level counts once the last two agree,
   // so a slowly settling strap never flips the channel map on one sample
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         strap_sync_r <= 3'h0;
      end else begin
         strap_sync_r <= {strap_sync_r[1:0], small_pkg_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         small_r <= 1'b0;
      end else if (strap_sync_r[1] == strap_sync_r[2]) begin
         small_r <= strap_sync_r[2];
      end
   end

   // write strobes, one per register that software can change
   assign wr_control = wr_pend_r && (addr_r == `ADC_IDX_CONTROL);
   assign wr_config  = wr_pend_r && (addr_r == `ADC_IDX_CONFIG);
   assign wr_mask    = wr_pend_r && (addr_r == `ADC_IDX_IRQ_MASK);

   // go may only start while powered; a write that clears power aborts a running conversion
   assign go_set = wr_control && hwdata_i[`ADC_GO_BIT] // RULE_07
                   && hwdata_i[`ADC_PWR_BIT] && (state_r == adc_ctrl_pkg::CONV_IDLE);

   // next control value; only a run in progress keeps go through a write, so a
   // write landing on the completion cycle cannot leave go stuck high
   always_comb begin
      control_nxt = control_r;
      if (wr_control) begin
         control_nxt = hwdata_i[7:0] & `ADC_CONTROL_WMASK;
         control_nxt[`ADC_GO_BIT] = go_set || (control_r[`ADC_GO_BIT] && hwdata_i[`ADC_PWR_BIT]
                                               && state_r == adc_ctrl_pkg::CONV_RUN);
      end else if (done_evt || !control_r[`ADC_PWR_BIT]) begin
         control_nxt[`ADC_GO_BIT] = 1'b0; // RULE_08
      end
   end

   // control register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         control_r <= `ADC_CONTROL_RST;
      end else begin
         control_r <= control_nxt;
      end
   end

   // config register: justify and pin configuration
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         config_r <= `ADC_CONFIG_RST;
      end else if (wr_config) begin
         config_r <= hwdata_i[7:0] & `ADC_CONFIG_WMASK;
      end
   end

   // bit-time source; stops while unpowered
   adc_clk_gen u_clk (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .run_i  (control_r[`ADC_PWR_BIT]), // RULE_03
      .sel_i  (control_r[`ADC_CLKSEL_HI:`ADC_CLKSEL_LO]), // RULE_06
      .tick_o (tick)
   );

   // conversion sequencer: run a fixed number of bit times, then complete
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         adc_ctrl_pkg::CONV_IDLE: if (go_set) state_nxt = adc_ctrl_pkg::CONV_RUN;
         adc_ctrl_pkg::CONV_RUN: begin
            if (!control_r[`ADC_PWR_BIT]) state_nxt = adc_ctrl_pkg::CONV_IDLE;
            else if (tick && bit_cnt_r == `ADC_CONV_TICKS - 4'h1) state_nxt = adc_ctrl_pkg::CONV_DONE;
         end
         adc_ctrl_pkg::CONV_DONE: state_nxt = adc_ctrl_pkg::CONV_IDLE;
         default: state_nxt = adc_ctrl_pkg::CONV_IDLE;
      endcase
   end
   assign done_evt = (state_r == adc_ctrl_pkg::CONV_DONE);

   // state register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_r <= adc_ctrl_pkg::CONV_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // bit-time counter inside a conversion
   always_ff @(posedge clk_i) begin
      if (!nrst_i || state_r != adc_ctrl_pkg::CONV_RUN) begin
         bit_cnt_r <= 4'h0;
      end else if (tick) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end

   // result pair loaded at completion
   adc_result_fmt u_fmt (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .load_i  (done_evt), // RULE_08
      .right_i (config_r[`ADC_JUSTIFY_BIT]),
      .data_i  (conv_data_i),
      .high_o  (res_high),
      .low_o   (res_low)
   );

   // sticky done flag, write one to clear; a same-cycle completion wins
   assign flag_clr = wr_pend_r && (addr_r == `ADC_IDX_IRQ_STATUS) && hwdata_i[0];
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         done_flag_r <= 1'b0;
      end else if (done_evt) begin
         done_flag_r <= 1'b1; // RULE_08
      end else if (flag_clr) begin
         done_flag_r <= 1'b0;
      end
   end

   // interrupt mask register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         done_mask_r <= 1'b0;
      end else if (wr_mask) begin
         done_mask_r <= hwdata_i[0];
      end
   end

   // level interrupt from a flip-flop; lags the flag by one cycle
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= done_flag_r && done_mask_r;
      end
   end

   // read mux; reserved bits read zero
   always_comb begin
      case (addr_r)
         `ADC_IDX_CONTROL:     rd_val = control_r & `ADC_CONTROL_WMASK;
         `ADC_IDX_CONFIG:      rd_val = config_r;
         `ADC_IDX_RESULT_HIGH: rd_val = res_high;
         `ADC_IDX_RESULT_LOW:  rd_val = res_low;
         `ADC_IDX_IRQ_STATUS:  rd_val = {7'h00, done_flag_r};
         `ADC_IDX_IRQ_MASK:    rd_val = {7'h00, done_mask_r};
         `ADC_IDX_VARIANT:     rd_val = {7'h00, small_r};
         default:              rd_val = 8'h00;
      endcase
   end

   // converter power follows the control bit one cycle later
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         conv_power_o <= 1'b0;
      end else begin
         conv_power_o <= control_r[`ADC_PWR_BIT]; // RULE_03
      end
   end

   // run level and bit-time pulses share one delay, so every pulse falls inside the run
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         conv_sample_o <= 1'b0;
      end else begin
         conv_sample_o <= (state_r == adc_ctrl_pkg::CONV_RUN);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         conv_tick_o <= 1'b0;
      end else begin
         conv_tick_o <= tick && (state_r == adc_ctrl_pkg::CONV_RUN);
      end
   end

   // pin configuration passed unchanged to the port logic
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pin_analog_config_o <= 4'h0;
      end else begin
         pin_analog_config_o <= config_r[`ADC_PCFG_HI:`ADC_PCFG_LO];
      end
   end

   // one-hot channel routing; nothing routed while off or to a missing channel
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_chan
         always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
               chan_enable_o[g] <= 1'b0;
            end else begin
               chan_enable_o[g] <= control_r[`ADC_PWR_BIT]
                                   && (control_r[`ADC_CHSEL_HI:`ADC_CHSEL_LO] == 3'(g)) // RULE_01
                                   && !(small_r && 3'(g) >= `ADC_SMALL_CHANNELS); // RULE_02
            end
         end
      end
   endgenerate
endmodule : adc_ctrl

// file: hdl/adc_ctrl_cfg.svh
// constants of the converter control register block
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
// register indices; the byte address on the bus is four times the index
`define ADC_IDX_CONTROL      8'h1F
`define ADC_IDX_CONFIG       8'h9F
`define ADC_IDX_RESULT_HIGH  8'hA0
`define ADC_IDX_RESULT_LOW   8'hA1
`define ADC_IDX_IRQ_STATUS   8'hA2
`define ADC_IDX_IRQ_MASK     8'hA3
`define ADC_IDX_VARIANT      8'hA4
// converter_control fields
`define ADC_CLKSEL_HI        7
`define ADC_CLKSEL_LO        6
`define ADC_CHSEL_HI         5
`define ADC_CHSEL_LO         3
`define ADC_GO_BIT           2
`define ADC_PWR_BIT          0
`define ADC_CONTROL_WMASK    8'hFD
// converter_config fields
`define ADC_JUSTIFY_BIT      7
`define ADC_PCFG_HI          3
`define ADC_PCFG_LO          0
`define ADC_CONFIG_WMASK     8'h8F
// reset values
`define ADC_CONTROL_RST      8'h00
`define ADC_CONFIG_RST       8'h00
// channels on the small package variant
`define ADC_SMALL_CHANNELS   3'h5
// internal rc oscillator period and derived cycle count at 20 MHz
`define ADC_CLK_PERIOD_NS    50
`define ADC_RC_PERIOD_NS     4000
`define ADC_RC_DIV           ((`ADC_RC_PERIOD_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
// divider ratios of the conversion clock
`define ADC_DIV_2            7'h01
`define ADC_DIV_8            7'h04
`define ADC_DIV_32           7'h10
`define ADC_DIV_RC           7'(`ADC_RC_DIV)
// conversion length in conversion bit times
`define ADC_CONV_TICKS       4'hC
`endif

// file: hdl/adc_ctrl_pkg.sv
// types of the converter control register block
package adc_ctrl_pkg;
   typedef enum logic [2:0] {
      CONV_IDLE = 3'b001,
      CONV_RUN  = 3'b010,
      CONV_DONE = 3'b100
   } conv_state_t;
   typedef enum logic [1:0] {
      CLK_DIV2  = 2'h0,
      CLK_DIV8  = 2'h1,
      CLK_DIV32 = 2'h2,
      CLK_RC    = 2'h3
   } clk_sel_t;
endpackage : adc_ctrl_pkg

// file: hdl/adc_clk_gen.sv
// conversion bit-time tick generator
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_clk_gen (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       run_i,
   input  wire logic [1:0] sel_i,
   output logic            tick_o
);
   logic [6:0] cnt_r;
   logic [6:0] limit;

   // divider end for the selected source; rc is modelled by a fixed slow divide
   always_comb begin
      case (adc_ctrl_pkg::clk_sel_t'(sel_i))
         adc_ctrl_pkg::CLK_DIV2:  limit = `ADC_DIV_2;
         adc_ctrl_pkg::CLK_DIV8:  limit = `ADC_DIV_8;
         adc_ctrl_pkg::CLK_DIV32: limit = `ADC_DIV_32;
         default:                 limit = `ADC_DIV_RC;
      endcase
   end

   // count stops while powered down so no toggling happens
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !run_i) begin
         cnt_r  <= 7'h00;
         tick_o <= 1'b0;
      end else if (cnt_r >= limit - 7'h01) begin
         cnt_r  <= 7'h00;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 7'h01;
         tick_o <= 1'b0;
      end
   end
endmodule : adc_clk_gen

// file: hdl/adc_result_fmt.sv
// justification of the ten-bit result across two byte registers
`timescale 1ns/1ps
module adc_result_fmt (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       load_i,
   input  wire logic       right_i,
   input  wire logic [9:0] data_i,
   output logic [7:0]      high_o,
   output logic [7:0]      low_o
);
   logic [9:0] res_r;

   // result captured on completion only
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         res_r <= 10'h000;
      end else if (load_i) begin
         res_r <= data_i;
      end
   end

   // format reapplied every cycle from the stored result, so the justify bit acts one cycle later
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         high_o <= 8'h00;
         low_o  <= 8'h00;
      end else if (right_i) begin
         high_o <= {6'h00, res_r[9:8]}; // RULE_04
         low_o  <= res_r[7:0];
      end else begin
         high_o <= res_r[9:2];
         low_o  <= {res_r[1:0], 6'h00}; // RULE_05
      end
   end
endmodule : adc_result_fmt

// file: dv/adc_ctrl_monitor.sv
// port checker for the converter register block
`timescale 1ns/1ps
module adc_ctrl_monitor (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        small_pkg_i,
   input wire logic        conv_power_o,
   input wire logic [7:0]  chan_enable_o,
   input wire logic        conv_sample_o,
   input wire logic        conv_tick_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // the slave never errors; a read stalls for exactly one cycle
   a_bus_okay: assert property (!hresp_o)
      else $error("error response");
   a_wait_one: assert property (!hreadyout_o |=> hreadyout_o)
      else $error("wait state longer than one cycle");
   a_read_upper: assert property (hrdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_chan_onehot: assert property ($onehot0(chan_enable_o))
      else $error("more than one channel routed");
   // strap age in cycles, saturating; the synchronised route settles a few cycles behind the pin
   logic [2:0] strap_age = 3'h0;
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !small_pkg_i) begin
         strap_age <= 3'h0;
      end else if (strap_age != 3'h7) begin
         strap_age <= strap_age + 3'h1;
      end
   end
   a_small_chan: assert property (strap_age == 3'h7 |-> chan_enable_o[7:5] == 3'h0)
      else $error("absent channel routed");
   a_power_off: assert property (!conv_power_o |=> !conv_sample_o || conv_power_o)
      else $error("conversion while powered down");
   a_tick_run: assert property (conv_tick_o |-> conv_sample_o || $past(conv_sample_o))
      else $error("bit tick outside conversion");
   a_conv_min: assert property ($rose(conv_sample_o) |-> conv_sample_o[*8])
      else $error("conversion too short");
   a_conv_end: assert property ($rose(conv_sample_o) |-> ##[12:1000] !conv_sample_o)
      else $error("conversion never completes");
   c_conv: cover property ($fell(conv_sample_o));
   c_tick: cover property (conv_tick_o);
   c_small: cover property (small_pkg_i && conv_sample_o);
endmodule : adc_ctrl_monitor
bind adc_ctrl adc_ctrl_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .small_pkg_i(small_pkg_i), .conv_power_o(conv_power_o),
   .chan_enable_o(chan_enable_o), .conv_sample_o(conv_sample_o), .conv_tick_o(conv_tick_o));

// file: dv/adc_conv_model.sv
// behavioural conversion core: code per routed channel
`timescale 1ns/1ps
module adc_conv_model (
   input  wire logic       clk_i,
   input  wire logic       sample_i,
   input  wire logic [7:0] chan_i,
   input  wire logic [9:0] seed_i,
   output logic      [9:0] data_o
);
   logic       hold_r = 1'h0;
   logic [9:0] last_r = 10'h155;
   // result stands through the run and one cycle after, then toggles so stale data never matches
   always_ff @(posedge clk_i) begin
      hold_r <= sample_i;
      last_r <= data_o;
   end
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      for (int k = 0; k < 8; k++) if (chan_i[k]) idx = k[2:0];
      data_o = (sample_i || hold_r) ? seed_i ^ {idx, 7'h0} : ~last_r;
   end
endmodule : adc_conv_model

// file: dv/adc_ctrl_tb_top.sv
// self-checking bench for the converter register block
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_ctrl_tb_top;
   localparam logic [31:0] A_CTL = `ADC_IDX_CONTROL * 4;
   localparam logic [31:0] A_CFG = `ADC_IDX_CONFIG * 4;
   localparam logic [31:0] A_HI  = `ADC_IDX_RESULT_HIGH * 4;
   localparam logic [31:0] A_LO  = `ADC_IDX_RESULT_LOW * 4;
   localparam logic [31:0] A_ST  = `ADC_IDX_IRQ_STATUS * 4;
   localparam logic [31:0] A_MSK = `ADC_IDX_IRQ_MASK * 4;
   localparam logic [31:0] A_VAR = `ADC_IDX_VARIANT * 4;
   logic        clk_i = 1'h0;
   logic        nrst_i = 1'h0;
   logic        small_r = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [15:0] lfsr = 16'hBCAA;
   logic [9:0]  seed = 10'h0;
   logic [31:0] hrdata;
   logic [9:0]  cdata;
   logic [7:0]  chan_en;
   logic [3:0]  pcfg;
   logic        hready, hresp, pwr, samp, tick, irq;
   int          err_count = 0;
   int          samples_checked = 0;
   adc_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(1'h1), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .small_pkg_i(small_r), .conv_data_i(cdata),
      .conv_power_o(pwr), .chan_enable_o(chan_en), .conv_sample_o(samp), .conv_tick_o(tick),
      .pin_analog_config_o(pcfg), .irq_o(irq));
   adc_conv_model core (.clk_i(clk_i), .sample_i(samp), .chan_i(chan_en), .seed_i(seed), .data_o(cdata));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : step
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bounded wait for the bus ready; running out ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (hready !== 1'h1 && n < 64);
      if (hready !== 1'h1) begin
         err_count++;
         results();
      end
   endtask : wait_rdy
   // one single word transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : xfer
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   initial begin
      int ch, div, nt, last, cyc, idx;
      logic [1:0] cs;
      logic [9:0] d;
      logic [7:0] ctl, cfg;
      logic just, msk, sm;
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'h1;
      // reset values, unmapped word ignored and read as zero
      rdchk(A_CTL, 32'h0);
      rdchk(A_CFG, 32'h0);
      rdchk(A_ST, 32'h0);
      rdchk(A_MSK, 32'h0);
      xfer(1'h1, 32'h300, 32'hFF);
      rdchk(32'h300, 32'h0);
      $display("test reset done");
      // every clock select, every justification, both variants, interrupt masked and unmasked
      for (int i = 0; i < 8; i++) begin
         sm = i[0];
         ch = (i * 5) % 8;
         cs = i[1:0];
         just = i[2];
         msk = i[1] ^ i[0];
         div = (cs == 2'h0) ? 1 : (cs == 2'h1) ? 4 : (cs == 2'h2) ? 16 : 80;
         lfsr = step(lfsr);
         small_r <= sm;
         seed <= lfsr[9:0];
         cfg = {just, lfsr[14:8]};
         ctl = {cs, ch[2:0], 3'h1};
         xfer(1'h1, A_CFG, {24'h0, cfg});
         rdchk(A_CFG, {24'h0, cfg & 8'h8F});
         chk(pcfg, cfg[3:0]);
         xfer(1'h1, A_MSK, {31'h0, msk});
         xfer(1'h1, A_CTL, {24'h0, ctl});
         repeat (4) @(posedge clk_i);
         idx = (sm && ch >= 5) ? 0 : ch;
         chk(pwr, 32'h1);
         chk(chan_en, (sm && ch >= 5) ? 32'h0 : 32'h1 << ch);
         xfer(1'h1, A_CTL, {24'h0, ctl | 8'h04});
         nt = 0;
         last = 0;
         for (cyc = 0; cyc < 1200; cyc++) begin
            @(posedge clk_i);
            if (tick === 1'h1) begin
               if (nt > 0) chk(cyc - last, div);
               last = cyc;
               nt++;
            end
            if (cyc > 0 && samp !== 1'h1) break;
         end
         if (cyc == 1200) begin
            err_count++;
            results();
         end
         chk(nt, 12);
         repeat (2 * div) @(posedge clk_i);
         d = lfsr[9:0] ^ {idx[2:0], 7'h0};
         rdchk(A_HI, just ? {30'h0, d[9:8]} : {24'h0, d[9:2]});
         rdchk(A_LO, just ? {24'h0, d[7:0]} : {24'h0, d[1:0], 6'h0});
         rdchk(A_CTL, {24'h0, ctl});
         rdchk(A_ST, 32'h1);
         chk(irq, msk);
         xfer(1'h1, A_ST, 32'h1);
         rdchk(A_ST, 32'h0);
         chk(irq, 32'h0);
         rdchk(A_VAR, {31'h0, sm});
         $display("test %0d done", i);
      end
      // clearing power mid-run aborts: no result flag, go cleared
      xfer(1'h1, A_CTL, 32'hC1);
      repeat (4) @(posedge clk_i);
      xfer(1'h1, A_CTL, 32'hC5);
      repeat (20) @(posedge clk_i);
      chk(samp, 32'h1);
      xfer(1'h1, A_CTL, 32'h00);
      repeat (3) @(posedge clk_i);
      chk(samp, 32'h0);
      rdchk(A_CTL, 32'h0);
      rdchk(A_ST, 32'h0);
      $display("test abort done");
      // start without power is refused, converter stays off
      xfer(1'h1, A_CTL, 32'h04);
      repeat (2) @(posedge clk_i);
      chk(samp, 32'h0);
      chk(pwr, 32'h0);
      rdchk(A_CTL, 32'h0);
      $display("test power off done");
      results();
   end
endmodule : adc_ctrl_tb_top
